// ==== pkg/touch_key_pkg.sv ====
// Constants shared by the touch key scan controller and its per-module slice.
// Assumes a 32-bit APB bus with byte addresses; every register is one word.
package touch_key_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_MODULES     = 5;
  localparam int KEYS_PER_MODULE = 4;
  localparam int ADDR_W          = 8;

  // ---------------------------------------------------------------
  // Global register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_TIMER_PRELOAD = 8'h00;
  localparam logic [7:0] OFF_GLOBAL_CTRL   = 8'h04;
  localparam logic [7:0] OFF_GLOBAL_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_GLOBAL_CNT_HI = 8'h0C;
  localparam logic [7:0] OFF_OSC_FREQ      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h18;

  // Module n occupies a 32-byte block; paddr[7:5] = MODULE_BLOCK_BASE + n
  localparam logic [2:0] MODULE_BLOCK_BASE = 3'h2;
  localparam logic [2:0] MREG_COUNT_LO     = 3'h0;
  localparam logic [2:0] MREG_COUNT_HI     = 3'h1;
  localparam logic [2:0] MREG_REF_CAP_LO   = 3'h2;
  localparam logic [2:0] MREG_REF_CAP_HI   = 3'h3;
  localparam logic [2:0] MREG_CTRL_A       = 3'h4;
  localparam logic [2:0] MREG_CTRL_B       = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GC_SLOT_OVF_BIT = 6;
  localparam int GC_START_BIT    = 5;
  localparam int GC_CF_OVF_BIT   = 4;
  localparam int GC_REF_OVF_BIT  = 3;
  localparam int GC_SHARED_BIT   = 2;
  localparam int GC_DIV_LSB      = 0;
  localparam int CA_KEY_SEL_LSB  = 6;
  localparam int CB_SLOT_CLK_BIT = 7;
  localparam int CB_REF_EN_BIT   = 5;
  localparam int CB_KEY_EN_BIT   = 4;
  localparam int IRQ_SLOT_BIT    = 0;
  localparam int IRQ_CF_BIT      = 1;
  localparam int IRQ_REF_BIT     = 2;

  localparam logic [7:0] CTRL_B_IMPL_MASK = 8'hBF;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_TIMER_PRELOAD = 8'h00;
  localparam logic [1:0] RST_OSC_FREQ      = 2'h3;
  localparam logic [9:0] RST_REF_CAP       = 10'h000;
  localparam logic [7:0] RST_CTRL_A        = 8'h00;
  localparam logic [7:0] RST_CTRL_B        = 8'h00;
  localparam logic [2:0] RST_IRQ_MASK      = 3'h0;
  localparam logic [4:0] SLOT_SUB_LAST     = 5'h1F;
  localparam logic [7:0] SLOT_TIMER_LAST   = 8'hFF;
  localparam logic [2:0] SYS_DIV4_MASK     = 3'h3;

endpackage

// ==== rtl/touch_key_module.sv ====
// One touch key module: C/F counter, 5-bit slot counter, 8-bit slot timer and its registers.
// Assumes key and reference oscillator edges arrive as one-cycle ticks synchronous to pclk.
`timescale 1ns/100ps
module touch_key_module (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        self_stop,
  input  wire logic        clear,
  input  wire logic        start_pulse,
  input  wire logic [7:0]  preload,
  input  wire logic [3:0]  key_tick,
  input  wire logic        ref_tick,
  input  wire logic        div4_tick,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_sel,
  input  wire logic [7:0]  wr_data,
  output logic      [15:0] count,
  output logic      [9:0]  ref_cap,
  output logic      [7:0]  ctrl_a,
  output logic      [7:0]  ctrl_b,
  output logic             done,
  output logic             slot_ovf,
  output logic             cf_ovf,
  output logic             key_osc_enable,
  output logic             reference_osc_enable
);

  typedef struct packed {
    logic [15:0] cf_cnt;
    logic [4:0]  sub_cnt;
    logic [7:0]  slot_tmr;
    logic        done;
    logic        slot_ovf;
    logic        cf_ovf;
    logic [9:0]  ref_cap;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
  } mod_state_t;

  mod_state_t q;
  mod_state_t d;
  logic       active;
  logic [1:0] key_select_field;
  logic       slot_tick;
  logic [16:0] cf_sum;

  // A module halted by its own overflow only matters when it keeps its own time slot
  assign active           = run & ~(self_stop & q.done);
  assign key_select_field = q.ctrl_a[touch_key_pkg::CA_KEY_SEL_LSB +: 2];
  assign slot_tick = q.ctrl_b[touch_key_pkg::CB_SLOT_CLK_BIT] ? div4_tick :
                     (ref_tick & q.ctrl_b[touch_key_pkg::CB_REF_EN_BIT]);
  assign cf_sum    = {1'b0, q.cf_cnt} + 17'h00001;

  always_comb begin
    d          = q;
    d.slot_ovf = 1'b0;
    d.cf_ovf   = 1'b0;
    if (active && q.ctrl_b[touch_key_pkg::CB_KEY_EN_BIT] && key_tick[key_select_field]) begin
      d.cf_cnt = cf_sum[15:0];
      d.cf_ovf = cf_sum[16];
    end
    if (active && slot_tick) begin
      d.sub_cnt = q.sub_cnt + 5'h01;
      if (q.sub_cnt == touch_key_pkg::SLOT_SUB_LAST) begin
        d.slot_tmr = q.slot_tmr + 8'h01;
        if (q.slot_tmr == touch_key_pkg::SLOT_TIMER_LAST) begin
          d.done     = 1'b1;
          d.slot_ovf = 1'b1;
        end
      end
    end
    if (clear) begin
      d.cf_cnt  = 16'h0000;
      d.sub_cnt = 5'h00;
    end
    if (start_pulse) begin
      d.slot_tmr = preload;
      d.sub_cnt  = 5'h00;
      d.done     = 1'b0;
    end
    if (wr_en) begin
      case (wr_sel)
        touch_key_pkg::MREG_REF_CAP_LO: d.ref_cap[7:0] = wr_data;
        touch_key_pkg::MREG_REF_CAP_HI: d.ref_cap[9:8] = wr_data[1:0];
        touch_key_pkg::MREG_CTRL_A:     d.ctrl_a       = wr_data;
        touch_key_pkg::MREG_CTRL_B:     d.ctrl_b       = wr_data & touch_key_pkg::CTRL_B_IMPL_MASK;
        default:                        d.ctrl_a       = q.ctrl_a;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{cf_cnt: 16'h0000, sub_cnt: 5'h00, slot_tmr: 8'h00, done: 1'b0,
             slot_ovf: 1'b0, cf_ovf: 1'b0, ref_cap: touch_key_pkg::RST_REF_CAP,
             ctrl_a: touch_key_pkg::RST_CTRL_A, ctrl_b: touch_key_pkg::RST_CTRL_B};
    end else begin
      q <= d;
    end
  end

  assign count                = q.cf_cnt;
  assign ref_cap              = q.ref_cap;
  assign ctrl_a               = q.ctrl_a;
  assign ctrl_b               = q.ctrl_b;
  assign done                 = q.done;
  assign slot_ovf             = q.slot_ovf;
  assign cf_ovf               = q.cf_ovf;
  // Oscillators run only while this module is counting
  assign key_osc_enable       = active & q.ctrl_b[touch_key_pkg::CB_KEY_EN_BIT];
  assign reference_osc_enable = active & q.ctrl_b[touch_key_pkg::CB_REF_EN_BIT];

endmodule

// ==== rtl/touch_key_scan_control.sv ====
// Shared control of the capacitive touch key scanner: APB registers, start/stop,
// reference counter with clock divider, overflow flags and the interrupt line.
// Assumes oscillator ticks are synchronous one-cycle pulses on pclk (40 MHz).
//
// How it works
// - Slot overflow comes after (256 minus preload) times 32 slot clocks.
// - Slot overflow flag reads 0 before and 1 after a slot overflow.
// - Selected slot overflow (module 0, or every module) raises the touch interrupt request.
// - That overflow stops all oscillators and switches off all detection counters.
// - Start bit at zero clears C/F counters, 16-bit counter and 5-bit slot counters.
// - The 8-bit slot timer preload survives the start bit going to zero.
// - Start bit rising turns counters on and gates oscillator clocks into them.
// - C/F counter overflow sets a sticky flag held until software clears it.
// - 16-bit counter overflow sets a sticky flag held until software clears it.
// - Shared-slot bit 0 uses own slot counters, 1 uses module 0's.
// - Divider field 00/01/10/11 clocks the 16-bit counter at sys/1, /2, /4, /8.
// - Five identical per-module register sets, modules 0 to 4.
// - Global control top bit reads zero; slot timer preload is RW, resets zero.
// - Oscillator frequency field 00..11 picks 500 to 2000 kHz, resets to 11.
// - Each module's key select field routes one of four keys to measurement.
// - Separate reference and key oscillator enables per module, 1 enables.
`timescale 1ns/100ps
module touch_key_scan_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [19:0] key_tick,
  input  wire logic [4:0]  ref_tick,
  output logic      [4:0]  key_osc_enable,
  output logic      [4:0]  reference_osc_enable,
  output logic      [9:0]  key_select_field,
  output logic      [1:0]  touch_osc_frequency_field,
  output logic      [49:0] ref_cap_trim,
  output logic             touch_interrupt_request,
  output logic             irq
);

  localparam int N = touch_key_pkg::NUM_MODULES;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  preload;
    logic        slot_ovf_flag;
    logic        start;
    logic        cf_ovf_flag;
    logic        ref_ovf_flag;
    logic        shared_slot;
    logic [1:0]  div_sel;
    logic [1:0]  osc_freq;
    logic [15:0] ref_cnt;
    logic [2:0]  prescale;
    logic        run;
    logic        start_pulse;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;

  // ---------------------------------------------------------------
  // Per-module wiring
  // ---------------------------------------------------------------
  logic [15:0] m_count [N];
  logic [9:0]  m_ref_cap [N];
  logic [7:0]  m_ctrl_a [N];
  logic [7:0]  m_ctrl_b [N];
  logic [N-1:0] m_done;
  logic [N-1:0] m_slot_ovf;
  logic [N-1:0] m_cf_ovf;
  logic [N-1:0] m_wr_en;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic        setup_phase;
  logic        access_phase;
  logic        wr_fire;
  logic        in_module_space;
  logic [2:0]  mod_idx;
  logic [2:0]  mreg_sel;
  logic        mapped;
  logic [7:0]  wbyte;

  assign setup_phase     = psel & ~penable;
  assign access_phase    = psel & penable;
  assign in_module_space = (paddr[7:5] >= touch_key_pkg::MODULE_BLOCK_BASE) &&
                           (paddr[7:5] < touch_key_pkg::MODULE_BLOCK_BASE + 3'(N));
  assign mod_idx         = paddr[7:5] - touch_key_pkg::MODULE_BLOCK_BASE;
  assign mreg_sel        = paddr[4:2];
  assign wbyte           = pwdata[7:0];

  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      if (in_module_space) begin
        mapped = (mreg_sel <= touch_key_pkg::MREG_CTRL_B);
      end else begin
        case (paddr)
          touch_key_pkg::OFF_TIMER_PRELOAD,
          touch_key_pkg::OFF_GLOBAL_CTRL,
          touch_key_pkg::OFF_GLOBAL_CNT_LO,
          touch_key_pkg::OFF_GLOBAL_CNT_HI,
          touch_key_pkg::OFF_OSC_FREQ,
          touch_key_pkg::OFF_IRQ_STATUS,
          touch_key_pkg::OFF_IRQ_MASK: mapped = 1'b1;
          default:                     mapped = 1'b0;
        endcase
      end
    end
  end

  // Zero wait states: read data is captured in the setup cycle so prdata comes from flops
  assign pready  = access_phase;
  assign pslverr = access_phase & ~mapped;
  assign wr_fire = access_phase & pwrite & mapped;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      m_wr_en[i] = wr_fire && in_module_space && (mod_idx == 3'(i));
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [7:0] gctrl_view;

  assign gctrl_view = {1'b0, q.slot_ovf_flag, q.start, q.cf_ovf_flag,
                       q.ref_ovf_flag, q.shared_slot, q.div_sel};

  always_comb begin
    rd_byte = 8'h00;
    if (in_module_space) begin
      case (mreg_sel)
        touch_key_pkg::MREG_COUNT_LO:   rd_byte = m_count[mod_idx][7:0];
        touch_key_pkg::MREG_COUNT_HI:   rd_byte = m_count[mod_idx][15:8];
        touch_key_pkg::MREG_REF_CAP_LO: rd_byte = m_ref_cap[mod_idx][7:0];
        touch_key_pkg::MREG_REF_CAP_HI: rd_byte = {6'h00, m_ref_cap[mod_idx][9:8]};
        touch_key_pkg::MREG_CTRL_A:     rd_byte = m_ctrl_a[mod_idx];
        touch_key_pkg::MREG_CTRL_B:     rd_byte = m_ctrl_b[mod_idx];
        default:                        rd_byte = 8'h00;
      endcase
    end else begin
      case (paddr)
        touch_key_pkg::OFF_TIMER_PRELOAD: rd_byte = q.preload;
        touch_key_pkg::OFF_GLOBAL_CTRL:   rd_byte = gctrl_view;
        touch_key_pkg::OFF_GLOBAL_CNT_LO: rd_byte = q.ref_cnt[7:0];
        touch_key_pkg::OFF_GLOBAL_CNT_HI: rd_byte = q.ref_cnt[15:8];
        touch_key_pkg::OFF_OSC_FREQ:      rd_byte = {6'h00, q.osc_freq};
        touch_key_pkg::OFF_IRQ_STATUS:    rd_byte = {5'h00, q.irq_status};
        touch_key_pkg::OFF_IRQ_MASK:      rd_byte = {5'h00, q.irq_mask};
        default:                          rd_byte = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Timing ticks
  // ---------------------------------------------------------------
  logic [2:0]  div_mask;
  logic        ref_tick_div;
  logic        div4_tick;
  logic [16:0] ref_sum;
  logic        slot_stop;
  logic        any_cf_ovf;

  always_comb begin
    case (q.div_sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      2'h3:    div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
  end

  assign ref_tick_div = ((q.prescale & div_mask) == div_mask);
  assign div4_tick    = ((q.prescale & touch_key_pkg::SYS_DIV4_MASK) == touch_key_pkg::SYS_DIV4_MASK);
  assign ref_sum      = {1'b0, q.ref_cnt} + 17'h00001;
  // Shared mode waits on module 0 alone, otherwise on every module's own counter
  assign slot_stop    = q.run & (q.shared_slot ? m_slot_ovf[0] :
                                 (&(m_done | m_slot_ovf)) & (|m_slot_ovf));
  assign any_cf_ovf   = |m_cf_ovf;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic start_rise;
  logic gc_write;
  logic ref_ovf_now;

  assign gc_write    = wr_fire && !in_module_space && (paddr == touch_key_pkg::OFF_GLOBAL_CTRL);
  assign start_rise  = gc_write && wbyte[touch_key_pkg::GC_START_BIT] && !q.start;
  assign ref_ovf_now = q.run && ref_tick_div && ref_sum[16];

  always_comb begin
    d             = q;
    d.start_pulse = 1'b0;
    d.prescale    = q.prescale + 3'h1;
    if (setup_phase) begin
      d.rdata = {24'h000000, rd_byte};
    end

    // Software writes; a global control flag is cleared by writing zero, an interrupt status bit by writing one
    if (wr_fire && !in_module_space) begin
      case (paddr)
        touch_key_pkg::OFF_TIMER_PRELOAD: d.preload = wbyte;
        touch_key_pkg::OFF_GLOBAL_CTRL: begin
          d.start       = wbyte[touch_key_pkg::GC_START_BIT];
          d.shared_slot = wbyte[touch_key_pkg::GC_SHARED_BIT];
          d.div_sel     = wbyte[touch_key_pkg::GC_DIV_LSB +: 2];
          d.slot_ovf_flag = q.slot_ovf_flag & wbyte[touch_key_pkg::GC_SLOT_OVF_BIT];
          d.cf_ovf_flag   = q.cf_ovf_flag & wbyte[touch_key_pkg::GC_CF_OVF_BIT];
          d.ref_ovf_flag  = q.ref_ovf_flag & wbyte[touch_key_pkg::GC_REF_OVF_BIT];
        end
        touch_key_pkg::OFF_OSC_FREQ:   d.osc_freq   = wbyte[1:0];
        touch_key_pkg::OFF_IRQ_STATUS: d.irq_status = q.irq_status & ~wbyte[2:0];
        touch_key_pkg::OFF_IRQ_MASK:   d.irq_mask   = wbyte[2:0];
        default:                       d.preload    = q.preload;
      endcase
    end

    if (start_rise) begin
      d.run         = 1'b1;
      d.start_pulse = 1'b1;
    end
    // Stopped means stopped: oscillators must not keep running with the start bit low
    if (gc_write && !wbyte[touch_key_pkg::GC_START_BIT]) d.run = 1'b0;

    if (q.run && ref_tick_div) begin
      d.ref_cnt = ref_sum[15:0];
    end
    if (!q.start) begin
      d.ref_cnt = 16'h0000;
    end

    // Hardware sets are applied last so a same-cycle clear never loses an event
    if (slot_stop) begin
      d.run           = 1'b0;
      d.slot_ovf_flag = 1'b1;
      d.irq_status[touch_key_pkg::IRQ_SLOT_BIT] = 1'b1;
    end
    if (any_cf_ovf) begin
      d.cf_ovf_flag = 1'b1;
      d.irq_status[touch_key_pkg::IRQ_CF_BIT] = 1'b1;
    end
    if (ref_ovf_now) begin
      d.ref_ovf_flag = 1'b1;
      d.irq_status[touch_key_pkg::IRQ_REF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{preload: touch_key_pkg::RST_TIMER_PRELOAD, slot_ovf_flag: 1'b0, start: 1'b0,
             cf_ovf_flag: 1'b0, ref_ovf_flag: 1'b0, shared_slot: 1'b0, div_sel: 2'h0,
             osc_freq: touch_key_pkg::RST_OSC_FREQ, ref_cnt: 16'h0000, prescale: 3'h0,
             run: 1'b0, start_pulse: 1'b0, irq_status: 3'h0,
             irq_mask: touch_key_pkg::RST_IRQ_MASK, rdata: 32'h00000000};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Module slices
  // ---------------------------------------------------------------
  // The preload register is never touched by the start bit; each slice copies it on start
  for (genvar g = 0; g < N; g++) begin : g_mod
    touch_key_module u_mod (
      .pclk                 (pclk),
      .presetn              (presetn),
      .run                  (q.run),
      .self_stop            (~q.shared_slot),
      .clear                (~q.start),
      .start_pulse          (q.start_pulse),
      .preload              (q.preload),
      .key_tick             (key_tick[4*g +: 4]),
      .ref_tick             (ref_tick[g]),
      .div4_tick            (div4_tick),
      .wr_en                (m_wr_en[g]),
      .wr_sel               (mreg_sel),
      .wr_data              (wbyte),
      .count                (m_count[g]),
      .ref_cap              (m_ref_cap[g]),
      .ctrl_a               (m_ctrl_a[g]),
      .ctrl_b               (m_ctrl_b[g]),
      .done                 (m_done[g]),
      .slot_ovf             (m_slot_ovf[g]),
      .cf_ovf               (m_cf_ovf[g]),
      .key_osc_enable       (key_osc_enable[g]),
      .reference_osc_enable (reference_osc_enable[g])
    );
    assign key_select_field[2*g +: 2] = m_ctrl_a[g][touch_key_pkg::CA_KEY_SEL_LSB +: 2];
    assign ref_cap_trim[10*g +: 10]   = m_ref_cap[g];
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                    = q.rdata;
  assign touch_osc_frequency_field = q.osc_freq;
  assign touch_interrupt_request   = q.irq_status[touch_key_pkg::IRQ_SLOT_BIT];
  assign irq                       = |(q.irq_status & q.irq_mask);

endmodule

// ==== verif/touch_key_scan_control_monitor.sv ====
// Port-level checks for touch_key_scan_control.
// Assumes the zero-wait APB timing and the register map of the design.
`timescale 1ns/100ps
module touch_key_scan_control_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [4:0]  key_osc_enable,
  input wire logic [4:0]  reference_osc_enable,
  input wire logic [9:0]  key_select_field,
  input wire logic [1:0]  touch_osc_frequency_field,
  input wire logic [49:0] ref_cap_trim,
  input wire logic        touch_interrupt_request
);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Assertions
  // ----
  a_freq_reset_value: assert property ($rose(presetn) |-> touch_osc_frequency_field == 2'h3)
    else $error("oscillator frequency field not 3 after reset");
  a_freq_write_lands: assert property (wr_acc && paddr == 8'h10
    |=> touch_osc_frequency_field == $past(pwdata[1:0])) else $error("frequency write lost");
  a_key_sel_write: assert property (wr_acc && paddr == 8'h50
    |=> key_select_field[1:0] == $past(pwdata[7:6])) else $error("key select write lost");
  a_trim_low_write: assert property (wr_acc && paddr == 8'h48
    |=> ref_cap_trim[7:0] == $past(pwdata[7:0])) else $error("trim write lost");
  a_key_enable_off: assert property (wr_acc && paddr == 8'h54 && !pwdata[4]
    |=> !key_osc_enable[0]) else $error("key oscillator still enabled");
  a_slot_stop_all: assert property ($rose(touch_interrupt_request)
    |-> key_osc_enable == 5'h0 && reference_osc_enable == 5'h0) else $error("oscillators run on");
  a_request_sticky: assert property (touch_interrupt_request
    && !(wr_acc && paddr == 8'h14 && pwdata[0]) |=> touch_interrupt_request)
    else $error("interrupt request dropped without clear");
  a_upper_read_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_error: assert property (psel && penable && paddr[7:5] == 3'h7 |-> pslverr)
    else $error("no error on unmapped module block");
endmodule
bind touch_key_scan_control touch_key_scan_control_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .key_osc_enable(key_osc_enable),
  .reference_osc_enable(reference_osc_enable), .key_select_field(key_select_field),
  .touch_osc_frequency_field(touch_osc_frequency_field), .ref_cap_trim(ref_cap_trim),
  .touch_interrupt_request(touch_interrupt_request));

// ==== verif/touch_key_scan_control_test.sv ====
// Self-checking bench: APB master, oscillator tick drivers and a read-result queue.
// Assumes a zero-wait APB slave and one-cycle ticks synchronous to pclk.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module touch_key_scan_control_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata, got, ev, lfsr = 32'h57BF;
  logic        pready, pslverr, tir, irq, err;
  logic [19:0] key_tick = 20'h0;
  logic [4:0]  ref_tick = 5'h0, koe, roe;
  logic [9:0]  ksel;
  logic [1:0]  ofreq;
  logic [49:0] trim;
  logic [31:0] exp_q[$];
  int          fail_count = 0, checks_done = 0, n, ticks;
  event        rd_ev;
  touch_key_scan_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_tick(key_tick), .ref_tick(ref_tick),
    .key_osc_enable(koe), .reference_osc_enable(roe), .key_select_field(ksel),
    .touch_osc_frequency_field(ofreq), .ref_cap_trim(trim), .touch_interrupt_request(tir),
    .irq(irq));
  initial forever #12.5 pclk = ~pclk;
  // ----
  // Bus tasks and result checker
  // ----
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Idle edge after each transfer keeps a driver from assigning twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin
        fail_count++;
        finish_test();
      end
      @(posedge pclk);
    end
    got = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
    -> rd_ev;
  endtask
  always @(rd_ev) begin
    ev = exp_q.pop_front();
    `CHK(got, ev)
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h3);
    rd(8'hE0, 32'h0);
    `CHK(err, 1'b1)
    wr(8'h04, 8'h87);
    rd(8'h04, 32'h07);
    wr(8'h10, 8'h01);
    `CHK(ofreq, 2'h1)
    for (int m = 0; m < 5; m++) begin
      b = 8'(8'h40 + 8'h20 * m);
      wr(b + 8'h10, {2'(m), 6'h0});
      wr(b + 8'h08, 8'(8'h5A + m));
      wr(b + 8'h14, 8'hFF);
      rd(b + 8'h14, 32'hBF);
      rd(b + 8'h10, {24'h0, 2'(m), 6'h0});
      `CHK(ksel[2*m +: 2], 2'(m))
      `CHK(trim[10*m +: 8], 8'(8'h5A + m))
      wr(b + 8'h14, 8'h00);
    end
    $display("test registers done");
    wr(8'h00, 8'hFE);
    wr(8'h54, 8'hB0);
    wr(8'h18, 8'h01);
    wr(8'h04, 8'h24);
    n = 0;
    ticks = 0;
    while (tir !== 1'b1) begin
      lfsr = lfsr_next(lfsr);
      key_tick <= (n > 1 && n < 100) ? {18'h0, lfsr[1:0]} : 20'h0;
      ref_tick <= lfsr[6:2];
      if (n > 1 && n < 100 && lfsr[0]) ticks++;
      n++;
      if (n > 600) begin
        fail_count++;
        finish_test();
      end
      @(posedge pclk);
    end
    `CHK(n >= 250 && n <= 266, 1'b1)
    `CHK(irq, 1'b1)
    `CHK(koe, 5'h0)
    `CHK(roe, 5'h0)
    rd(8'h04, 32'h64);
    rd(8'h40, 32'(ticks));
    wr(8'h18, 8'h00);
    `CHK(irq, 1'b0)
    wr(8'h14, 8'h01);
    `CHK(tir, 1'b0)
    wr(8'h04, 8'h04);
    rd(8'h40, 32'h0);
    rd(8'h00, 32'hFE);
    $display("test slot overflow done");
    ref_tick <= 5'h0;
    wr(8'h00, 8'hF0);
    for (int d = 0; d < 4; d++) begin
      wr(8'h04, 8'(8'h20 + d));
      xfer(1'b0, 8'h08, 8'h00);
      b = got[7:0];
      repeat (61) @(posedge pclk);
      xfer(1'b0, 8'h08, 8'h00);
      `CHK(8'(got[7:0] - b), 8'(64 >> d))
      wr(8'h04, 8'h00);
    end
    $display("test divider done");
    // Slot clock from the silent reference oscillator, so no slot overflow ends the run
    wr(8'h54, 8'h30);
    wr(8'h04, 8'h20);
    key_tick <= 20'h1;
    repeat (65540) @(posedge pclk);
    key_tick <= 20'h0;
    rd(8'h04, 32'h38);
    wr(8'h04, 8'h38);
    rd(8'h04, 32'h38);
    wr(8'h04, 8'h20);
    rd(8'h04, 32'h20);
    $display("test counter overflow done");
    // Let the checker take the last read before the verdict
    @(posedge pclk);
    finish_test();
  end
endmodule
